// File: logic/wss_cfg.svh
`ifndef WSS_CFG_SVH
`define WSS_CFG_SVH

// ***********************************************
// Register offsets
// ***********************************************
`define WSS_ADDR_WAKE_A      7'h46
`define WSS_ADDR_WAKE_B      7'h47
`define WSS_ADDR_LEVEL       7'h48
`define WSS_ADDR_OVERLOAD    7'h54
`define WSS_ADDR_OPEN_LOAD   7'h55

// ***********************************************
// Field positions
// ***********************************************
`define WSS_WA_LIN2_BIT      7
`define WSS_WA_LIN1_BIT      6
`define WSS_WA_CAN_BIT       5
`define WSS_WA_TIMER_BIT     4
`define WSS_WA_WK_LSB        0
`define WSS_WB_GPIO_LSB      4
`define WSS_LV_DEV_BIT       7
`define WSS_LV_STRAP_BIT     6
`define WSS_LV_GPIO_LSB      4
`define WSS_LV_WK_LSB        0
`define WSS_HS_LSB           0

// ***********************************************
// Widths, reset values and masks
// ***********************************************
`define WSS_WK_W             3
`define WSS_GPIO_W           2
`define WSS_HS_W             4
`define WSS_WA_W             7
`define WSS_BYTE_ZERO        8'h00
`define WSS_WA_RESET         7'h00
`define WSS_WB_RESET         2'h0
`define WSS_HS_RESET         4'h0
`define WSS_WK_RESET         3'h0
`define WSS_GPIO_RESET       2'h0
`define WSS_WA_KEEP_MASK     7'h7F
`define WSS_WB_KEEP_MASK     2'h3
`define WSS_HS_KEEP_MASK     4'hF

`endif

// File: logic/wss_pkg.sv
package wss_pkg;

  // SBC operating mode as seen by this block
  typedef enum logic [2:0] {
    WSS_MODE_NORMAL    = 3'b000,
    WSS_MODE_STOP      = 3'b001,
    WSS_MODE_SLEEP     = 3'b010,
    WSS_MODE_RESTART   = 3'b011,
    WSS_MODE_FAIL_SAFE = 3'b100
  } wss_mode_t;

  // Function selected for a GPIO pin
  typedef enum logic [2:0] {
    WSS_GPIO_OFF       = 3'b000,
    WSS_GPIO_WAKE      = 3'b001,
    WSS_GPIO_LOW_SIDE  = 3'b010,
    WSS_GPIO_HIGH_SIDE = 3'b011,
    WSS_GPIO_OTHER     = 3'b100
  } wss_gpio_fn_t;

  // Host access operation
  typedef enum logic [1:0] {
    WSS_OP_IDLE  = 2'b00,
    WSS_OP_READ  = 2'b01,
    WSS_OP_CLEAR = 2'b10
  } wss_op_t;

  typedef struct packed {
    wss_op_t    op;
    logic [6:0] addr;
  } wss_req_t;

  // One-cycle wake event pulses
  typedef struct packed {
    logic       second_lin;
    logic       first_lin;
    logic       can_bus;
    logic       timer;
    logic [2:0] wake_input;
    logic [1:0] gpio;
  } wss_wake_evt_t;

  // Pin levels, synchronous to clk_i
  typedef struct packed {
    logic       test_mode_pin;
    logic       interrupt_pullup_strap;
    logic [1:0] gpio_level;
    logic [2:0] wake_input_level;
  } wss_pins_t;

  // One-cycle fault pulses per high-side switch
  typedef struct packed {
    logic [3:0] overload;
    logic [3:0] open_load;
  } wss_fault_evt_t;

endpackage

// File: logic/wss_sticky_bank.sv
`timescale 1ns/1ps
`include "wss_cfg.svh"

// Bank of sticky flags; a set in the same cycle as a clear wins
module wss_sticky_bank
  import wss_pkg::*;
#(
  parameter int         W         = 4,
  parameter logic [W-1:0] RST_VAL   = '0,
  parameter logic [W-1:0] KEEP_MASK = '0
) (
  input  wire logic         clk_i,
  input  wire logic         srst_i,
  input  wire logic [W-1:0] set_i,
  input  wire logic [W-1:0] clr_i,
  input  wire logic         restart_i,
  output logic      [W-1:0] flags_o
);

  logic [W-1:0] flags_r;
  logic [W-1:0] flags_nxt;

  // Next flag values
  always_comb begin
    flags_nxt = flags_r & ~clr_i;
    if (restart_i) begin
      flags_nxt = flags_nxt & KEEP_MASK;
    end
    flags_nxt = flags_nxt | set_i;
  end

  // Flag storage
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      flags_r <= RST_VAL;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign flags_o = flags_r;

endmodule

// File: logic/wss_status_regs.sv
// Behaviour
// R1: Wake status A: bit 7 LIN 2, 6 LIN 1, 5 CAN, 4 timer, 2..0 wake inputs 3..1, set on a wake.
// R2: A wake out of fail-safe sets its wake source flag just as a wake from sleep does.
// R3: Wake status B holds the GPIO 2 wake flag at bit 5 and GPIO 1 at bit 4, the rest reserved.
// R4: A restart keeps the two GPIO wake flags of wake status B and forces its other bits to zero.
// R5: Every reserved bit of these registers reads as zero.
// R6: Input level bit 7 shows the test pin mode, 0 user mode and 1 development mode.
// R7: Input level bit 6 shows the interrupt pin strap, 1 when an external pull-up is present.
// R8: Input level bits 2..0 show wake inputs 3..1 and bits 5 and 4 show the second and first GPIO.
// R9: GPIO level bits refresh in normal and stop mode when the GPIO is a wake input or a switch.
// R10: In cyclic sense or wake operation the wake input levels hold the latest sample.
// R11: Cyclic sampling never applies to the GPIO level bits.
// R12: A GPIO level is reported even while the pin serves as a low-side or high-side switch.
// R13: After power-on or soft reset level bits 5..3 are zero and bits 7, 6, 2..0 follow the pins.
// R14: Overload status latches one overcurrent-or-overtemperature flag per switch, 4..1 at 3..0.
// R15: Open-load status latches one open-load flag per switch, switch 4..1 at bits 3..0.
// R16: Latched flags stay set until the host clears them through a register access.
`timescale 1ns/1ps
`include "wss_cfg.svh"

module wss_status_regs
  import wss_pkg::*;
(
  input  wire logic           clk_i,
  input  wire logic           srst_i,
  input  wire logic           soft_reset_i,
  input  wire logic           restart_i,
  input  wire wss_mode_t      mode_i,
  input  wire wss_gpio_fn_t   gpio_a_fn_i,
  input  wire wss_gpio_fn_t   gpio_b_fn_i,
  input  wire logic           cyclic_mode_i,
  input  wire logic           sample_i,
  input  wire wss_pins_t      pins_i,
  input  wire wss_wake_evt_t  wake_evt_i,
  input  wire wss_fault_evt_t fault_evt_i,
  input  wire wss_req_t       req_i,
  output logic      [7:0]     rdata_o,
  output logic                rvalid_o,
  output logic                wake_pending_o
);

  // ***********************************************
  // Helper functions
  // ***********************************************

  // Address compare used by every register decode
  function automatic logic hit(input logic [6:0] a, input logic [6:0] ref_addr);
    hit = (a == ref_addr);
  endfunction

  // A GPIO level is refreshed only for the listed functions and modes
  function automatic logic gpio_live(input wss_gpio_fn_t fn, input wss_mode_t m);
    logic mode_ok;
    logic fn_ok;
    mode_ok = (m == WSS_MODE_NORMAL) || (m == WSS_MODE_STOP);
    fn_ok   = (fn == WSS_GPIO_WAKE) || (fn == WSS_GPIO_LOW_SIDE)
              || (fn == WSS_GPIO_HIGH_SIDE);
    gpio_live = mode_ok && fn_ok;
  endfunction

  // ***********************************************
  // Access decode
  // ***********************************************

  logic clr_cmd;
  logic rd_cmd;
  logic sel_wake_a;
  logic sel_wake_b;
  logic sel_level;
  logic sel_overload;
  logic sel_open_load;
  logic local_rst;

  // Soft reset acts like power-on reset on every register of the group
  assign local_rst     = srst_i | soft_reset_i;
  assign clr_cmd       = (req_i.op == WSS_OP_CLEAR);
  assign rd_cmd        = (req_i.op == WSS_OP_READ) | clr_cmd;
  assign sel_wake_a    = hit(req_i.addr, `WSS_ADDR_WAKE_A);
  assign sel_wake_b    = hit(req_i.addr, `WSS_ADDR_WAKE_B);
  assign sel_level     = hit(req_i.addr, `WSS_ADDR_LEVEL);
  assign sel_overload  = hit(req_i.addr, `WSS_ADDR_OVERLOAD);
  assign sel_open_load = hit(req_i.addr, `WSS_ADDR_OPEN_LOAD);

  // ***********************************************
  // Wake source flags
  // ***********************************************

  logic [`WSS_WA_W-1:0]   wake_a_set;
  logic [`WSS_WA_W-1:0]   wake_a_clr;
  logic [`WSS_WA_W-1:0]   wake_a_flags;
  logic [`WSS_GPIO_W-1:0] wake_b_set;
  logic [`WSS_GPIO_W-1:0] wake_b_clr;
  logic [`WSS_GPIO_W-1:0] wake_b_flags;

  // Events are taken in every mode, so a fail-safe exit flags its source too
  assign wake_a_set = {wake_evt_i.second_lin,             // R1 R2
                       wake_evt_i.first_lin,
                       wake_evt_i.can_bus,
                       wake_evt_i.timer,
                       wake_evt_i.wake_input};
  assign wake_b_set = wake_evt_i.gpio;                    // R3 R2
  assign wake_a_clr = {`WSS_WA_W{clr_cmd & sel_wake_a}};  // R16
  assign wake_b_clr = {`WSS_GPIO_W{clr_cmd & sel_wake_b}}; // R16

  // Wake status A keeps its flags through restart
  wss_sticky_bank #(
    .W         (`WSS_WA_W),
    .RST_VAL   (`WSS_WA_RESET),
    .KEEP_MASK (`WSS_WA_KEEP_MASK)
  ) u_wake_a (
    .clk_i     (clk_i),
    .srst_i    (local_rst),
    .set_i     (wake_a_set),
    .clr_i     (wake_a_clr),
    .restart_i (restart_i),
    .flags_o   (wake_a_flags)
  );

  // Wake status B stores only the GPIO flags; the rest are constant zero
  wss_sticky_bank #(
    .W         (`WSS_GPIO_W),
    .RST_VAL   (`WSS_WB_RESET),
    .KEEP_MASK (`WSS_WB_KEEP_MASK)
  ) u_wake_b (
    .clk_i     (clk_i),
    .srst_i    (local_rst),
    .set_i     (wake_b_set),
    .clr_i     (wake_b_clr),
    .restart_i (restart_i),       // R4
    .flags_o   (wake_b_flags)
  );

  // ***********************************************
  // High-side switch fault flags
  // ***********************************************

  logic [`WSS_HS_W-1:0] ovl_clr;
  logic [`WSS_HS_W-1:0] ovl_flags;
  logic [`WSS_HS_W-1:0] opl_clr;
  logic [`WSS_HS_W-1:0] opl_flags;

  assign ovl_clr = {`WSS_HS_W{clr_cmd & sel_overload}};   // R16
  assign opl_clr = {`WSS_HS_W{clr_cmd & sel_open_load}};  // R16

  // Overcurrent and overtemperature share one flag per switch
  wss_sticky_bank #(
    .W         (`WSS_HS_W),
    .RST_VAL   (`WSS_HS_RESET),
    .KEEP_MASK (`WSS_HS_KEEP_MASK)
  ) u_overload (
    .clk_i     (clk_i),
    .srst_i    (local_rst),
    .set_i     (fault_evt_i.overload), // R14
    .clr_i     (ovl_clr),
    .restart_i (restart_i),
    .flags_o   (ovl_flags)
  );

  // Open-load flags per switch
  wss_sticky_bank #(
    .W         (`WSS_HS_W),
    .RST_VAL   (`WSS_HS_RESET),
    .KEEP_MASK (`WSS_HS_KEEP_MASK)
  ) u_open_load (
    .clk_i     (clk_i),
    .srst_i    (local_rst),
    .set_i     (fault_evt_i.open_load), // R15
    .clr_i     (opl_clr),
    .restart_i (restart_i),
    .flags_o   (opl_flags)
  );

  // ***********************************************
  // Input level status
  // ***********************************************

  logic                   dev_lvl_r;
  logic                   dev_lvl_nxt;
  logic                   strap_r;
  logic                   strap_nxt;
  logic                   strap_done_r;
  logic                   strap_done_nxt;
  logic [`WSS_GPIO_W-1:0] gpio_lvl_r;
  logic [`WSS_GPIO_W-1:0] gpio_lvl_nxt;
  logic [`WSS_WK_W-1:0]   wk_lvl_r;
  logic [`WSS_WK_W-1:0]   wk_lvl_nxt;

  // Strap is caught once after each reset release, then held; a pin that
  // moves later is not a configuration change
  always_comb begin
    dev_lvl_nxt    = pins_i.test_mode_pin;              // R6
    strap_nxt      = strap_r;
    strap_done_nxt = 1'b1;
    if (!strap_done_r) begin
      strap_nxt = pins_i.interrupt_pullup_strap;        // R7
    end
  end

  // GPIO levels hold their last value when not refreshed; no cyclic path
  always_comb begin
    gpio_lvl_nxt = gpio_lvl_r;
    if (gpio_live(gpio_a_fn_i, mode_i)) begin           // R9 R12
      gpio_lvl_nxt[0] = pins_i.gpio_level[0];           // R8 R11
    end
    if (gpio_live(gpio_b_fn_i, mode_i)) begin           // R9 R12
      gpio_lvl_nxt[1] = pins_i.gpio_level[1];           // R8 R11
    end
  end

  // Wake input levels: live, or the sample taken by the cyclic sampler
  always_comb begin
    wk_lvl_nxt = pins_i.wake_input_level;               // R8
    if (cyclic_mode_i) begin
      wk_lvl_nxt = wk_lvl_r;
      if (sample_i) begin
        wk_lvl_nxt = pins_i.wake_input_level;           // R10
      end
    end
  end

  // Level storage; reset clears all, pin bits follow from the next edge
  always_ff @(posedge clk_i) begin
    if (local_rst) begin
      dev_lvl_r    <= 1'b0;
      strap_r      <= 1'b0;
      strap_done_r <= 1'b0;
      gpio_lvl_r   <= `WSS_GPIO_RESET;                   // R13
      wk_lvl_r     <= `WSS_WK_RESET;
    end else begin
      dev_lvl_r    <= dev_lvl_nxt;
      strap_r      <= strap_nxt;
      strap_done_r <= strap_done_nxt;
      gpio_lvl_r   <= gpio_lvl_nxt;
      wk_lvl_r     <= wk_lvl_nxt;                        // R13
    end
  end

  // ***********************************************
  // Register images
  // ***********************************************

  logic [7:0] img_wake_a;
  logic [7:0] img_wake_b;
  logic [7:0] img_level;
  logic [7:0] img_overload;
  logic [7:0] img_open_load;

  // Reserved positions are tied low in every image
  always_comb begin
    img_wake_a    = `WSS_BYTE_ZERO;                      // R5
    img_wake_a[`WSS_WA_LIN2_BIT]  = wake_a_flags[6];     // R1
    img_wake_a[`WSS_WA_LIN1_BIT]  = wake_a_flags[5];
    img_wake_a[`WSS_WA_CAN_BIT]   = wake_a_flags[4];
    img_wake_a[`WSS_WA_TIMER_BIT] = wake_a_flags[3];
    img_wake_a[`WSS_WA_WK_LSB +: `WSS_WK_W] = wake_a_flags[2:0];
    img_wake_b    = `WSS_BYTE_ZERO;                      // R5
    img_wake_b[`WSS_WB_GPIO_LSB +: `WSS_GPIO_W] = wake_b_flags; // R3
    img_level     = `WSS_BYTE_ZERO;                      // R5
    img_level[`WSS_LV_DEV_BIT]   = dev_lvl_r;            // R6
    img_level[`WSS_LV_STRAP_BIT] = strap_r;              // R7
    img_level[`WSS_LV_GPIO_LSB +: `WSS_GPIO_W] = gpio_lvl_r; // R8
    img_level[`WSS_LV_WK_LSB +: `WSS_WK_W]     = wk_lvl_r;   // R8
    img_overload  = `WSS_BYTE_ZERO;                      // R5
    img_overload[`WSS_HS_LSB +: `WSS_HS_W]  = ovl_flags; // R14
    img_open_load = `WSS_BYTE_ZERO;                      // R5
    img_open_load[`WSS_HS_LSB +: `WSS_HS_W] = opl_flags; // R15
  end

  // ***********************************************
  // Read port
  // ***********************************************

  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic       rvalid_r;
  logic       rvalid_nxt;
  logic       pend_r;
  logic       pend_nxt;

  // Returns the value before any clear issued by the same access;
  // unmapped addresses answer zero
  always_comb begin
    rdata_nxt  = rdata_r;
    rvalid_nxt = rd_cmd;
    if (rd_cmd) begin
      rdata_nxt = `WSS_BYTE_ZERO;
      if (sel_wake_a) begin
        rdata_nxt = img_wake_a;
      end else if (sel_wake_b) begin
        rdata_nxt = img_wake_b;
      end else if (sel_level) begin
        rdata_nxt = img_level;
      end else if (sel_overload) begin
        rdata_nxt = img_overload;
      end else if (sel_open_load) begin
        rdata_nxt = img_open_load;
      end
    end
    pend_nxt = (|wake_a_flags) | (|wake_b_flags);
  end

  // Output flops
  always_ff @(posedge clk_i) begin
    if (local_rst) begin
      rdata_r  <= `WSS_BYTE_ZERO;
      rvalid_r <= 1'b0;
      pend_r   <= 1'b0;
    end else begin
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      pend_r   <= pend_nxt;
    end
  end

  assign rdata_o        = rdata_r;
  assign rvalid_o       = rvalid_r;
  assign wake_pending_o = pend_r;   // One cycle behind the flags

endmodule

// File: verification/wss_status_checker.sv
`timescale 1ns/1ps
`include "wss_cfg.svh"

// ************************************************
// Port checks of the status register bank
// ************************************************
module wss_status_checker
  import wss_pkg::*;
(
  input wire logic           clk_i,
  input wire logic           srst_i,
  input wire logic           soft_reset_i,
  input wire wss_wake_evt_t  wake_evt_i,
  input wire wss_fault_evt_t fault_evt_i,
  input wire wss_req_t       req_i,
  input wire logic [7:0]     rdata_o,
  input wire logic           rvalid_o,
  input wire logic           wake_pending_o
);
  // Either reset wipes all state, so both silence the checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i || soft_reset_i);

  logic acc;
  logic acc_a;
  logic clr_a;
  logic clr_ovl;
  // Access taken at this edge; accesses and clears of the latched registers
  assign acc     = (req_i.op == WSS_OP_READ) || (req_i.op == WSS_OP_CLEAR);
  assign acc_a   = acc && (req_i.addr == `WSS_ADDR_WAKE_A);
  assign clr_a   = (req_i.op == WSS_OP_CLEAR) && (req_i.addr == `WSS_ADDR_WAKE_A);
  assign clr_ovl = (req_i.op == WSS_OP_CLEAR) && (req_i.addr == `WSS_ADDR_OVERLOAD);

  property p_answer; acc |=> rvalid_o; endproperty
  property p_no_spurious; rvalid_o |-> $past(acc); endproperty
  property p_rsv_a;
    rvalid_o && $past(req_i.addr) == `WSS_ADDR_WAKE_A |-> rdata_o[3] == 1'b0;
  endproperty
  property p_rsv_b;
    rvalid_o && $past(req_i.addr) == `WSS_ADDR_WAKE_B
      |-> rdata_o[7:6] == 2'h0 && rdata_o[3:0] == 4'h0;
  endproperty
  property p_rsv_lvl;
    rvalid_o && $past(req_i.addr) == `WSS_ADDR_LEVEL |-> rdata_o[3] == 1'b0;
  endproperty
  property p_rsv_hs;
    rvalid_o && $past(req_i.addr) inside {`WSS_ADDR_OVERLOAD, `WSS_ADDR_OPEN_LOAD}
      |-> rdata_o[7:4] == 4'h0;
  endproperty
  // Event, one cycle with no clear, then an access must still see the flag
  property p_wake_latch;
    wake_evt_i.second_lin ##1 !clr_a ##1 acc_a |=> rdata_o[7];
  endproperty
  property p_fault_latch;
    fault_evt_i.overload[3] ##1 !clr_ovl ##1 (acc && req_i.addr == `WSS_ADDR_OVERLOAD)
      |=> rdata_o[3];
  endproperty
  property p_pending; wake_evt_i != '0 |-> ##[1:2] wake_pending_o; endproperty

  a_answer:      assert property (p_answer) else $error("no answer to an access");
  a_no_spurious: assert property (p_no_spurious) else $error("answer without access");
  a_rsv_a:       assert property (p_rsv_a) else $error("wake A reserved bit set");
  a_rsv_b:       assert property (p_rsv_b) else $error("wake B reserved bit set");
  a_rsv_lvl:     assert property (p_rsv_lvl) else $error("level reserved bit set");
  a_rsv_hs:      assert property (p_rsv_hs) else $error("switch reserved bit set");
  a_wake_latch:  assert property (p_wake_latch) else $error("wake flag not latched");
  a_fault_latch: assert property (p_fault_latch) else $error("overload not latched");
  a_pending:     assert property (p_pending) else $error("wake pending missing");

  c_clear:   cover property (rvalid_o && $past(req_i.op) == WSS_OP_CLEAR);
  c_pending: cover property (wake_pending_o);
  c_fault:   cover property (fault_evt_i.overload[3] ##2 acc);
endmodule

bind wss_status_regs wss_status_checker wss_status_checker_inst (
  .clk_i(clk_i), .srst_i(srst_i), .soft_reset_i(soft_reset_i), .wake_evt_i(wake_evt_i),
  .fault_evt_i(fault_evt_i), .req_i(req_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
  .wake_pending_o(wake_pending_o));

// File: verification/wss_host_model.sv
`timescale 1ns/1ps

// ************************************************
// Host side: one register access at a time
// ************************************************
module wss_host_model
  import wss_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  input  wire logic       rvalid_i,
  output wss_req_t        req_o
);
  initial req_o = '{op: WSS_OP_IDLE, addr: 7'h00};

  // Request stands for one edge; the answer is taken at the edge after that
  task automatic access(input wss_op_t op, input logic [6:0] addr,
                        output logic [7:0] data, output logic ok);
    @(posedge clk_i);
    req_o <= '{op: op, addr: addr};
    @(posedge clk_i);
    // Released address flips so a stale value is never mistaken for a hold
    req_o <= '{op: WSS_OP_IDLE, addr: ~addr};
    // Sampled at the edge that closes the one cycle in which the answer stands
    @(posedge clk_i);
    data = rdata_i;
    ok = rvalid_i;
  endtask
endmodule

// File: verification/wss_status_regs_tb_top.sv
`timescale 1ns/1ps

module wss_status_regs_tb_top
  import wss_pkg::*;
;
  logic clk_i, srst_i, soft_reset_i, restart_i, cyclic_mode_i, sample_i, rvalid_o;
  logic wake_pending_o;
  logic [7:0] rdata_o;
  wss_mode_t mode_i;
  wss_gpio_fn_t gpio_a_fn_i, gpio_b_fn_i;
  wss_pins_t pins_i;
  wss_wake_evt_t wake_evt_i;
  wss_fault_evt_t fault_evt_i;
  wss_req_t req_i;
  int miscompares = 0;
  int n_tests = 0;
  int cycles = 0;
  logic [6:0] rst_addr [6] = '{7'h46, 7'h47, 7'h54, 7'h55, 7'h10, 7'h48};
  logic [7:0] rst_exp [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hC5};

  wss_status_regs wss_status_regs_inst (.clk_i(clk_i), .srst_i(srst_i),
    .soft_reset_i(soft_reset_i), .restart_i(restart_i), .mode_i(mode_i),
    .gpio_a_fn_i(gpio_a_fn_i), .gpio_b_fn_i(gpio_b_fn_i), .cyclic_mode_i(cyclic_mode_i),
    .sample_i(sample_i), .pins_i(pins_i), .wake_evt_i(wake_evt_i), .fault_evt_i(fault_evt_i),
    .req_i(req_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .wake_pending_o(wake_pending_o));
  wss_host_model wss_host_model_inst (.clk_i(clk_i), .rdata_i(rdata_o), .rvalid_i(rvalid_o),
    .req_o(req_i));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // Hang guard, far above the roughly 130 cycles the tests need
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One access through the host, answer and data both compared
  task automatic acc(input wss_op_t op, input logic [6:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    wss_host_model_inst.access(op, addr, d, ok);
    chk("rvalid", 8'h01, {7'h00, ok});
    chk($sformatf("register %h", addr), exp, d);
  endtask

  // One-cycle events; c is {sample, restart, soft reset}
  task automatic pulse(input wss_wake_evt_t w, input wss_fault_evt_t f, input logic [2:0] c);
    @(posedge clk_i);
    wake_evt_i <= w;
    fault_evt_i <= f;
    {sample_i, restart_i, soft_reset_i} <= c;
    @(posedge clk_i);
    wake_evt_i <= '0;
    fault_evt_i <= '0;
    {sample_i, restart_i, soft_reset_i} <= 3'h0;
  endtask

  initial begin
    srst_i = 1'b1;
    {soft_reset_i, restart_i, cyclic_mode_i, sample_i} = 4'h0;
    mode_i = WSS_MODE_SLEEP;
    gpio_a_fn_i = WSS_GPIO_OFF;
    gpio_b_fn_i = WSS_GPIO_OFF;
    pins_i = 7'h7D;
    wake_evt_i = '0;
    fault_evt_i = '0;
    repeat (10) @(posedge clk_i);
    srst_i <= 1'b0;
    foreach (rst_addr[i]) acc(WSS_OP_READ, rst_addr[i], rst_exp[i]);
    $display("test reset values done");
    // Each wake source alone, woken out of fail-safe
    @(posedge clk_i);
    mode_i <= WSS_MODE_FAIL_SAFE;
    for (int i = 0; i < 7; i++) begin
      pulse(wss_wake_evt_t'(9'h004 << i), '0, 3'h0);
      acc(WSS_OP_CLEAR, 7'h46, (i < 3) ? 8'h01 << i : 8'h10 << (i - 3));
    end
    acc(WSS_OP_READ, 7'h46, 8'h00);
    pulse(9'h002, '0, 3'h0);
    pulse(9'h001, '0, 3'h2);
    acc(WSS_OP_READ, 7'h47, 8'h30);
    chk("wake pending", 8'h01, {7'h00, wake_pending_o});
    acc(WSS_OP_CLEAR, 7'h47, 8'h30);
    acc(WSS_OP_READ, 7'h47, 8'h00);
    chk("wake pending", 8'h00, {7'h00, wake_pending_o});
    $display("test wake flags done");
    pulse('0, 8'hA5, 3'h0);
    acc(WSS_OP_CLEAR, 7'h54, 8'h0A);
    acc(WSS_OP_CLEAR, 7'h55, 8'h05);
    acc(WSS_OP_READ, 7'h54, 8'h00);
    acc(WSS_OP_READ, 7'h55, 8'h00);
    $display("test switch faults done");
    // GPIO levels follow only in normal or stop with a qualifying function
    @(posedge clk_i);
    mode_i <= WSS_MODE_NORMAL;
    gpio_a_fn_i <= WSS_GPIO_LOW_SIDE;
    gpio_b_fn_i <= WSS_GPIO_HIGH_SIDE;
    acc(WSS_OP_READ, 7'h48, 8'hF5);
    @(posedge clk_i);
    mode_i <= WSS_MODE_STOP;
    gpio_a_fn_i <= WSS_GPIO_WAKE;
    pins_i <= 7'h6D;
    acc(WSS_OP_READ, 7'h48, 8'hD5);
    @(posedge clk_i);
    mode_i <= WSS_MODE_SLEEP;
    pins_i <= 7'h75;
    acc(WSS_OP_READ, 7'h48, 8'hD5);
    $display("test gpio levels done");
    @(posedge clk_i);
    // GPIO levels stay live in cyclic mode while wake levels wait for a sample
    cyclic_mode_i <= 1'b1;
    mode_i <= WSS_MODE_NORMAL;
    pins_i <= 7'h72;
    acc(WSS_OP_READ, 7'h48, 8'hE5);
    pulse('0, '0, 3'h4);
    acc(WSS_OP_READ, 7'h48, 8'hE2);
    $display("test cyclic sampling done");
    @(posedge clk_i);
    cyclic_mode_i <= 1'b0;
    mode_i <= WSS_MODE_SLEEP;
    pulse(9'h100, '0, 3'h0);
    pulse('0, '0, 3'h1);
    acc(WSS_OP_READ, 7'h48, 8'hC2);
    acc(WSS_OP_READ, 7'h46, 8'h00);
    $display("test soft reset done");
    end_of_test();
  end
endmodule
